// ===== design/clock_manager_pkg.sv
// constants of the clock manager status and interrupt block
package clock_manager_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] IRQ_ENABLE_SET_OFS = 6'h00;
    localparam logic [5:0] IRQ_DISABLE_SET_OFS = 6'h04;
    localparam logic [5:0] CLOCK_STATUS_OFS = 6'h08;
    localparam logic [5:0] IRQ_MASK_VIEW_OFS = 6'h0c;
    localparam logic [5:0] OSC_CTRL_OFS = 6'h10;
    localparam logic [5:0] PLL_CONFIG_REG_OFS = 6'h14;
    localparam logic [5:0] MASTER_CTRL_OFS = 6'h18;
    localparam logic [5:0] PROG_ENABLE_OFS = 6'h1c;
    localparam logic [5:0] PROG_CTRL0_OFS = 6'h20;
    localparam logic [5:0] PROG_CTRL1_OFS = 6'h24;
    localparam logic [5:0] PROG_CTRL2_OFS = 6'h28;
    // status and interrupt bit positions
    localparam int unsigned OSC_STABLE_POS = 0;
    localparam int unsigned PLL_LOCK_POS = 2;
    localparam int unsigned MCK_READY_POS = 3;
    localparam int unsigned PROG_READY_LSB = 8;
    localparam int unsigned NUM_PROG = 3;
    localparam logic [31:0] EVENT_MASK = 32'h0000_070d;
    // oscillator control fields
    localparam int unsigned OSC_ENABLE_POS = 0;
    localparam int unsigned OSC_BYPASS_POS = 1;
    localparam int unsigned OSC_COUNT_LSB = 8;
    localparam int unsigned OSC_COUNT_W = 8;
    localparam int unsigned OSC_COUNT_SHIFT = 3;
    // pll settle field
    localparam int unsigned PLL_COUNT_LSB = 8;
    localparam int unsigned PLL_COUNT_W = 6;
    // clock control fields: source select and divisor select
    localparam int unsigned SRC_LSB = 0;
    localparam int unsigned DIV_LSB = 2;
    localparam int unsigned CTRL_W = 5;
    localparam logic [2:0] DIV_RESERVED = 3'h7;
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_PLL = 2'h3;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
endpackage

// ===== design/clock_manager_status_irq.sv
// clock manager status, interrupt mask and clock prescalers behind an avalon slave
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module clock_manager_status_irq (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic slow_clk_i,
    output logic irq_o,
    output logic mck_tick_o,
    output logic [2:0] prog_clk_tick_o
);
    localparam int unsigned NCLK = clock_manager_pkg::NUM_PROG + 1;
    localparam int unsigned OSC_CNT_W = clock_manager_pkg::OSC_COUNT_W + clock_manager_pkg::OSC_COUNT_SHIFT;
    localparam int unsigned PLL_CNT_W = clock_manager_pkg::PLL_COUNT_W;

    typedef enum logic [1:0] {osc_off, osc_wait, osc_up} osc_state_e;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // last count of a divide by 2**code; reserved code never hits
    function automatic logic div_hit(input logic [5:0] cnt, input logic [2:0] code);
        logic [5:0] last;
        last = 6'((7'h01 << code) - 7'h01);
        div_hit = (code != clock_manager_pkg::DIV_RESERVED) && (cnt == last);
    endfunction

    // bus slave: one wait cycle, then a single cycle with waitrequest low
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_acc, rd_cap;
    logic [31:0] wmask;
    assign wr_acc = avs_write_i && !wait_q;
    assign rd_cap = avs_read_i && wait_q;
    assign wmask = avs_writedata_i & lane_mask(avs_byteenable_i);

    // configuration state
    logic [31:0] osc_ctrl_q, osc_ctrl_d;
    logic [31:0] pll_cfg_q, pll_cfg_d;
    logic [clock_manager_pkg::CTRL_W-1:0] clk_ctrl_q [NCLK], clk_ctrl_d [NCLK];
    logic [NCLK-1:0] cfg_wr;
    logic [2:0] prog_en_q, prog_en_d;
    logic [31:0] irq_en_q, irq_en_d;
    logic pll_wr;

    // slow clock pin synchroniser
    logic slow_meta_q, slow_sync_q, slow_prev_q, slow_tick;
    assign slow_tick = slow_sync_q && !slow_prev_q;

    // oscillator, pll and divider state
    osc_state_e osc_q, osc_d;
    logic [OSC_CNT_W-1:0] osc_cnt_q, osc_cnt_d;
    logic [clock_manager_pkg::PLL_COUNT_W-1:0] pll_cnt_q, pll_cnt_d;
    logic pll_busy_q, pll_busy_d, lock_q, lock_d;
    logic [5:0] div_cnt_q [NCLK], div_cnt_d [NCLK];
    logic [NCLK-1:0] tick_q, tick_d, ready_q, ready_d, run;
    logic irq_q, irq_d;
    logic [31:0] status;
    // master clock is always enabled; programmable clocks run on their enable bits
    logic [NCLK-1:0] clk_en;
    assign clk_en = {prog_en_q, 1'b1};

    always_comb begin
        status = clock_manager_pkg::RESET_VALUE;
        status[clock_manager_pkg::OSC_STABLE_POS] = (osc_q == osc_up);
        status[clock_manager_pkg::PLL_LOCK_POS] = lock_q;
        status[clock_manager_pkg::MCK_READY_POS] = ready_q[0];
        status[clock_manager_pkg::PROG_READY_LSB +: 3] = ready_q[NCLK-1:1];
    end

    always_comb begin
        wait_d = !(wait_q && (avs_read_i || avs_write_i));
        rdata_d = rdata_q;
        if (rd_cap) begin
            if (avs_address_i == clock_manager_pkg::CLOCK_STATUS_OFS) begin
                rdata_d = status;
            end else if (avs_address_i == clock_manager_pkg::IRQ_MASK_VIEW_OFS) begin
                rdata_d = ~irq_en_q & clock_manager_pkg::EVENT_MASK;
            end else if (avs_address_i == clock_manager_pkg::OSC_CTRL_OFS) begin
                rdata_d = osc_ctrl_q;
            end else if (avs_address_i == clock_manager_pkg::PLL_CONFIG_REG_OFS) begin
                rdata_d = pll_cfg_q;
            end else if (avs_address_i == clock_manager_pkg::MASTER_CTRL_OFS) begin
                rdata_d = 32'(clk_ctrl_q[0]);
            end else if (avs_address_i == clock_manager_pkg::PROG_ENABLE_OFS) begin
                rdata_d = 32'(prog_en_q);
            end else if (avs_address_i == clock_manager_pkg::PROG_CTRL0_OFS) begin
                rdata_d = 32'(clk_ctrl_q[1]);
            end else if (avs_address_i == clock_manager_pkg::PROG_CTRL1_OFS) begin
                rdata_d = 32'(clk_ctrl_q[2]);
            end else if (avs_address_i == clock_manager_pkg::PROG_CTRL2_OFS) begin
                rdata_d = 32'(clk_ctrl_q[3]);
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // register writes take effect at the edge where waitrequest is low
    always_comb begin
        osc_ctrl_d = osc_ctrl_q;
        pll_cfg_d = pll_cfg_q;
        prog_en_d = prog_en_q;
        irq_en_d = irq_en_q;
        clk_ctrl_d = clk_ctrl_q;
        cfg_wr = '0;
        pll_wr = 1'b0;
        if (wr_acc) begin
            if (avs_address_i == clock_manager_pkg::IRQ_ENABLE_SET_OFS) begin
                irq_en_d = irq_en_q | (wmask & clock_manager_pkg::EVENT_MASK);
            end else if (avs_address_i == clock_manager_pkg::IRQ_DISABLE_SET_OFS) begin
                irq_en_d = irq_en_q & ~wmask;
            end else if (avs_address_i == clock_manager_pkg::OSC_CTRL_OFS) begin
                osc_ctrl_d = (osc_ctrl_q & ~lane_mask(avs_byteenable_i)) | (wmask & 32'h0000_ff03);
            end else if (avs_address_i == clock_manager_pkg::PLL_CONFIG_REG_OFS) begin
                pll_cfg_d = (pll_cfg_q & ~lane_mask(avs_byteenable_i)) | (wmask & 32'h0000_3f00);
                pll_wr = 1'b1;
            end else if (avs_address_i == clock_manager_pkg::MASTER_CTRL_OFS && avs_byteenable_i[0]) begin
                clk_ctrl_d[0] = avs_writedata_i[clock_manager_pkg::CTRL_W-1:0];
                cfg_wr[0] = 1'b1;
            end else if (avs_address_i == clock_manager_pkg::PROG_ENABLE_OFS && avs_byteenable_i[0]) begin
                prog_en_d = avs_writedata_i[2:0];
            end else if (avs_address_i == clock_manager_pkg::PROG_CTRL0_OFS && avs_byteenable_i[0]) begin
                clk_ctrl_d[1] = avs_writedata_i[clock_manager_pkg::CTRL_W-1:0];
                cfg_wr[1] = 1'b1;
            end else if (avs_address_i == clock_manager_pkg::PROG_CTRL1_OFS && avs_byteenable_i[0]) begin
                clk_ctrl_d[2] = avs_writedata_i[clock_manager_pkg::CTRL_W-1:0];
                cfg_wr[2] = 1'b1;
            end else if (avs_address_i == clock_manager_pkg::PROG_CTRL2_OFS && avs_byteenable_i[0]) begin
                clk_ctrl_d[3] = avs_writedata_i[clock_manager_pkg::CTRL_W-1:0];
                cfg_wr[3] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            osc_ctrl_q <= 32'h0000_0000;
            pll_cfg_q <= 32'h0000_0000;
            prog_en_q <= 3'h0;
            irq_en_q <= 32'h0000_0000;
            for (int i = 0; i < NCLK; i++) begin
                clk_ctrl_q[i] <= '0;
            end
        end else begin
            osc_ctrl_q <= osc_ctrl_d;
            pll_cfg_q <= pll_cfg_d;
            prog_en_q <= prog_en_d;
            irq_en_q <= irq_en_d;
            clk_ctrl_q <= clk_ctrl_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            slow_meta_q <= 1'b0;
            slow_sync_q <= 1'b0;
            slow_prev_q <= 1'b0;
        end else begin
            slow_meta_q <= slow_clk_i;
            slow_sync_q <= slow_meta_q;
            slow_prev_q <= slow_sync_q;
        end
    end

    // oscillator start-up and pll settle counters
    always_comb begin
        osc_d = osc_q;
        osc_cnt_d = osc_cnt_q;
        pll_cnt_d = pll_cnt_q;
        pll_busy_d = pll_busy_q;
        lock_d = lock_q;
        if (osc_ctrl_q[clock_manager_pkg::OSC_BYPASS_POS]) begin
            osc_d = osc_up;
        end else if (!osc_ctrl_q[clock_manager_pkg::OSC_ENABLE_POS]) begin
            osc_d = osc_off;
        end else begin
            case (osc_q)
                osc_off: begin
                    osc_d = osc_wait;
                    osc_cnt_d = {osc_ctrl_q[clock_manager_pkg::OSC_COUNT_LSB +: clock_manager_pkg::OSC_COUNT_W],
                                 3'h0};
                end
                osc_wait: begin
                    if (osc_cnt_q == '0) begin
                        osc_d = osc_up;
                    end else if (slow_tick) begin
                        osc_cnt_d = osc_cnt_q - OSC_CNT_W'(1);
                    end
                end
                default: begin
                    osc_d = osc_up;
                end
            endcase
        end
        if (pll_wr) begin
            lock_d = 1'b0;
            pll_busy_d = 1'b1;
            pll_cnt_d = avs_writedata_i[clock_manager_pkg::PLL_COUNT_LSB +: clock_manager_pkg::PLL_COUNT_W];
        end else if (pll_busy_q) begin
            if (pll_cnt_q == '0) begin
                lock_d = 1'b1;
                pll_busy_d = 1'b0;
            end else if (slow_tick) begin
                pll_cnt_d = pll_cnt_q - PLL_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            osc_q <= osc_off;
            osc_cnt_q <= '0;
            pll_cnt_q <= '0;
            pll_busy_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            osc_q <= osc_d;
            osc_cnt_q <= osc_cnt_d;
            pll_cnt_q <= pll_cnt_d;
            pll_busy_q <= pll_busy_d;
            lock_q <= lock_d;
        end
    end

    // index 0 is the master clock, 1 to 3 the programmable clocks
    always_comb begin
        div_cnt_d = div_cnt_q;
        tick_d = '0;
        ready_d = ready_q;
        for (int i = 0; i < NCLK; i++) begin
            logic [1:0] src;
            logic [2:0] code;
            src = clk_ctrl_q[i][clock_manager_pkg::SRC_LSB +: 2];
            code = clk_ctrl_q[i][clock_manager_pkg::DIV_LSB +: 3];
            run[i] = clk_en[i];
            case (src)
                clock_manager_pkg::SRC_SLOW: run[i] = run[i] && slow_tick;
                clock_manager_pkg::SRC_MAIN: run[i] = run[i] && (osc_q == osc_up);
                clock_manager_pkg::SRC_PLL: run[i] = run[i] && lock_q;
                default: run[i] = 1'b0;
            endcase
            if (cfg_wr[i] || !clk_en[i]) begin
                div_cnt_d[i] = 6'h00;
                ready_d[i] = 1'b0;
            end else if (run[i]) begin
                if (div_hit(div_cnt_q[i], code)) begin
                    div_cnt_d[i] = 6'h00;
                    tick_d[i] = 1'b1;
                    ready_d[i] = 1'b1;
                end else begin
                    div_cnt_d[i] = div_cnt_q[i] + 6'h01;
                end
            end
        end
        irq_d = |(status & irq_en_q);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tick_q <= '0;
            ready_q <= '0;
            irq_q <= 1'b0;
            for (int i = 0; i < NCLK; i++) begin
                div_cnt_q[i] <= 6'h00;
            end
        end else begin
            tick_q <= tick_d;
            ready_q <= ready_d;
            irq_q <= irq_d;
            div_cnt_q <= div_cnt_d;
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign irq_o = irq_q;
    assign mck_tick_o = tick_q[0];
    assign prog_clk_tick_o = tick_q[NCLK-1:1];

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    reserved_div_a: assert property (tick_q[1] |-> $past(clk_ctrl_q[1][4:2]) != 3'h7)
        else $error("tick from reserved divisor code");
    irq_enable_a: assert property (wr_acc && avs_address_i == 6'h00 && wmask[0] |=> irq_en_q[0])
        else $error("enable-set write did not unmask");
    irq_disable_a: assert property (wr_acc && avs_address_i == 6'h04 && wmask[2] |=> !irq_en_q[2])
        else $error("disable-set write did not mask");
    status_read_a: assert property (rd_cap && avs_address_i == 6'h08 |=>
        avs_readdata_o[1] == 1'b0 && avs_readdata_o[2] == $past(lock_q))
        else $error("status read wrong");
    mck_ready_a: assert property (cfg_wr[0] |=> !ready_q[0])
        else $error("master ready not cleared");
    prog_ready_a: assert property (!prog_en_q[0] |=> !ready_q[1])
        else $error("disabled clock reads ready");
    mask_view_a: assert property (rd_cap && avs_address_i == 6'h0c |=> avs_readdata_o[0] == !$past(irq_en_q[0]))
        else $error("mask view polarity wrong");
    osc_wait_a: assert property (osc_q == osc_wait && osc_cnt_q != '0 && !osc_ctrl_q[1] |=> !status[0])
        else $error("oscillator stable before count");
    osc_bypass_a: assert property (osc_ctrl_q[1] |-> ##[1:2] status[0])
        else $error("bypass did not set stable");
    pll_write_a: assert property (pll_wr |=> !lock_q ##1 !lock_q || pll_cnt_q == '0)
        else $error("lock not cleared by write");
    irq_level_a: assert property (irq_o == |($past(status) & $past(irq_en_q)))
        else $error("interrupt output mismatch");
endmodule

// ===== dv/tb.sv
// self-checking testbench of the clock manager status and interrupt block
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
    logic core_clk_i;
    logic rst_n_i;
    logic [5:0] avs_address_i;
    logic avs_read_i;
    logic avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0] avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic slow_clk_i;
    logic irq_o;
    logic mck_tick_o;
    logic [2:0] prog_clk_tick_o;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [31:0] q;
    int g;

    clock_manager_status_irq u_clock_manager_status_irq (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .slow_clk_i(slow_clk_i), .irq_o(irq_o),
        .mck_tick_o(mck_tick_o), .prog_clk_tick_o(prog_clk_tick_o)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // slow clock: one rising edge every 10 core cycles
    initial begin
        slow_clk_i = 1'b0;
        forever begin
            repeat (5) @(posedge core_clk_i);
            slow_clk_i <= ~slow_clk_i;
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one avalon access: hold until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] rq);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        rq = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge core_clk_i);
        if (n >= 50) begin
            error_cnt++;
            test_done();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] rq);
        bus(1'b0, a, 32'h0000_0000, rq);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    function automatic logic tick(input int sel);
        return (sel == 3) ? mck_tick_o : prog_clk_tick_o[sel];
    endfunction

    // cycles between two ticks of one output; 300 means none seen
    task automatic tick_gap(input int sel, output int gap);
        int n;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (tick(sel) !== 1'b1 && n < 300);
        gap = 0;
        do begin
            @(posedge core_clk_i);
            gap++;
        end while (tick(sel) !== 1'b1 && gap < 300);
    endtask

    initial begin
        rst_n_i = 1'b0;
        avs_address_i = 6'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0000_0000;
        avs_byteenable_i = 4'hf;
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(clock_manager_pkg::IRQ_MASK_VIEW_OFS, q);
        `CHK(q, clock_manager_pkg::EVENT_MASK);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q, 32'h0000_0000);
        `CHK(irq_o, 1'b0);
        rd(6'h3c, q);
        `CHK(q, 32'h0000_0000);
        $display("reset values done");

        wr(clock_manager_pkg::IRQ_ENABLE_SET_OFS, 32'h0000_0001);
        rd(clock_manager_pkg::IRQ_MASK_VIEW_OFS, q);
        `CHK(q, 32'h0000_070c);
        wr(clock_manager_pkg::IRQ_ENABLE_SET_OFS, 32'h0000_0000);
        rd(clock_manager_pkg::IRQ_MASK_VIEW_OFS, q);
        `CHK(q, 32'h0000_070c);
        wr(clock_manager_pkg::IRQ_DISABLE_SET_OFS, 32'h0000_0000);
        rd(clock_manager_pkg::IRQ_MASK_VIEW_OFS, q);
        `CHK(q, 32'h0000_070c);
        wr(clock_manager_pkg::IRQ_ENABLE_SET_OFS, 32'h0000_070d);
        rd(clock_manager_pkg::IRQ_MASK_VIEW_OFS, q);
        `CHK(q, 32'h0000_0000);
        wr(clock_manager_pkg::IRQ_DISABLE_SET_OFS, 32'h0000_0408);
        rd(clock_manager_pkg::IRQ_MASK_VIEW_OFS, q);
        `CHK(q, 32'h0000_0408);
        wr(clock_manager_pkg::IRQ_DISABLE_SET_OFS, 32'h0000_070d);
        wr(clock_manager_pkg::IRQ_MASK_VIEW_OFS, 32'h0000_0000);
        rd(clock_manager_pkg::IRQ_MASK_VIEW_OFS, q);
        `CHK(q, 32'h0000_070d);
        $display("mask set and clear done");

        wr(clock_manager_pkg::OSC_CTRL_OFS, 32'h0000_0002);
        idle(3);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[0], 1'b1);
        `CHK(q[1], 1'b0);
        `CHK(irq_o, 1'b0);
        wr(clock_manager_pkg::IRQ_ENABLE_SET_OFS, 32'h0000_0001);
        idle(3);
        `CHK(irq_o, 1'b1);
        wr(clock_manager_pkg::IRQ_DISABLE_SET_OFS, 32'h0000_0001);
        idle(3);
        `CHK(irq_o, 1'b0);
        wr(clock_manager_pkg::IRQ_ENABLE_SET_OFS, 32'h0000_0001);
        wr(clock_manager_pkg::OSC_CTRL_OFS, 32'h0000_0000);
        idle(3);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[0], 1'b0);
        `CHK(irq_o, 1'b0);
        $display("bypass and interrupt done");

        // start-up count 1 means 8 slow ticks, about 80 core cycles
        wr(clock_manager_pkg::OSC_CTRL_OFS, 32'h0000_0101);
        idle(50);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[0], 1'b0);
        idle(60);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[0], 1'b1);
        `CHK(irq_o, 1'b1);
        wr(clock_manager_pkg::IRQ_DISABLE_SET_OFS, 32'h0000_0001);
        $display("oscillator start-up done");

        // settle count 4 means about 40 core cycles
        wr(clock_manager_pkg::PLL_CONFIG_REG_OFS, 32'h0000_0400);
        idle(15);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[2], 1'b0);
        idle(40);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[2], 1'b1);
        wr(clock_manager_pkg::PLL_CONFIG_REG_OFS, 32'h0000_0400);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[2], 1'b0);
        $display("pll lock done");

        wr(clock_manager_pkg::OSC_CTRL_OFS, 32'h0000_0002);
        for (int c = 0; c < 7; c++) begin
            wr(clock_manager_pkg::MASTER_CTRL_OFS, 32'(c * 4 + 1));
            tick_gap(3, g);
            `CHK(32'(g), 32'(1 << c));
            rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
            `CHK(q[3], 1'b1);
        end
        // pll source at full rate, then slow source divided by 2 (a slow tick every 10 cycles)
        wr(clock_manager_pkg::MASTER_CTRL_OFS, 32'h0000_0003);
        tick_gap(3, g);
        `CHK(32'(g), 32'(1));
        wr(clock_manager_pkg::MASTER_CTRL_OFS, 32'h0000_0004);
        tick_gap(3, g);
        `CHK(32'(g), 32'(20));
        wr(clock_manager_pkg::MASTER_CTRL_OFS, 32'h0000_001d);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[3], 1'b0);
        tick_gap(3, g);
        `CHK(32'(g), 32'(300));
        $display("master prescaler done");

        wr(clock_manager_pkg::PROG_ENABLE_OFS, 32'h0000_0007);
        for (int i = 0; i < 3; i++) begin
            wr(clock_manager_pkg::PROG_CTRL0_OFS + 6'(4 * i), 32'((i + 1) * 4 + 1));
            tick_gap(i, g);
            `CHK(32'(g), 32'(2 << i));
        end
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[10:8], 3'h7);
        wr(clock_manager_pkg::IRQ_ENABLE_SET_OFS, 32'h0000_0700);
        idle(3);
        `CHK(irq_o, 1'b1);
        wr(clock_manager_pkg::PROG_ENABLE_OFS, 32'h0000_0000);
        idle(3);
        rd(clock_manager_pkg::CLOCK_STATUS_OFS, q);
        `CHK(q[10:8], 3'h0);
        `CHK(irq_o, 1'b0);
        $display("programmable clocks done");
        test_done();
    end
endmodule
